// *** hw/riu_top.sv ***
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "riu_params.svh"
// Rotate instruction unit with a classic Wishbone register slave
module riu_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core state view
  output logic [7:0] wreg_o,
  output logic [7:0] status_o
);
  import riu_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    riu_state_e state;
    logic [15:0] instr;
    riu_op_e op;
    logic dest;
    logic [11:0] fadr;
    logic [7:0] opnd;
    logic [7:0] res;
    logic cout;
    logic neg;
    logic zero;
    logic [7:0] wreg;
    logic [7:0] status;
    logic [3:0] bank_select_register;
    logic ext;
    logic [11:0] index;
    logic [11:0] maddr;
    logic ack;
    logic [31:0] dat;
  } riu_st_s;

  riu_st_s st;
  riu_st_s next_st;

  logic req;
  logic busy;
  logic wr_ok;
  logic mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] alu_res;
  logic alu_cout;
  logic alu_neg;
  logic alu_zero;
  logic [7:0] f_field;
  logic a_bit;
  logic [11:0] dec_fadr;
  riu_op_e dec_op;

  // ==========================================================
  // Submodules
  // ==========================================================
  riu_mem u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // Operand comes straight from the read port during process phase
  riu_alu u_alu (
    .op_i(st.op),
    .opnd_i(mem_rdata),
    .cin_i(st.status[`RIU_ST_C]),
    .res_o(alu_res),
    .cout_o(alu_cout),
    .neg_o(alu_neg),
    .zero_o(alu_zero)
  );

  // ==========================================================
  // Decode
  // ==========================================================
  // Bus handshake terms; ack drops one cycle after it is given
  assign req = cyc_i & stb_i & ~st.ack;
  assign busy = (st.state != RIU_IDLE);
  // Writes while an instruction runs are refused so flags stay coherent
  assign wr_ok = req & we_i & sel_i[0] & ~busy;
  assign f_field = st.instr[7:0];
  assign a_bit = st.instr[`RIU_IN_A];

  always_comb begin
    case (st.instr[15:10])
      `RIU_OPC_RLC: dec_op = RIU_OP_RLC;
      `RIU_OPC_RLN: dec_op = RIU_OP_RLN;
      `RIU_OPC_RRC: dec_op = RIU_OP_RRC;
      default: dec_op = RIU_OP_NONE;
    endcase
  end

  // File operand address
  always_comb begin
    if (a_bit) begin
      dec_fadr = {st.bank_select_register, f_field};
    end else if (st.ext && (f_field <= `RIU_IDX_MAX)) begin
      dec_fadr = st.index + {4'h0, f_field};
    end else if (f_field < `RIU_ACC_SPLIT) begin
      dec_fadr = {`RIU_ACC_LO_BANK, f_field};
    end else begin
      dec_fadr = {`RIU_ACC_HI_BANK, f_field};
    end
  end

  // ==========================================================
  // Memory port
  // ==========================================================
  // Execution owns the port while busy; bus window otherwise
  assign mem_addr = busy ? st.fadr : st.maddr;
  assign mem_we = ((st.state == RIU_Q4) & (st.op != RIU_OP_NONE) & st.dest)
                  | (wr_ok & (adr_i == `RIU_OFF_MDATA));
  assign mem_wdata = busy ? st.res : dat_i[7:0];

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    // Bus access, answered one cycle after it is taken
    if (req) begin
      next_st.ack = 1'b1;
      next_st.dat = 32'h0000_0000;
      if (!we_i) begin
        case (adr_i)
          `RIU_OFF_INSTR: next_st.dat = {16'h0000, st.instr};
          `RIU_OFF_WREG: next_st.dat = {24'h00_0000, st.wreg};
          `RIU_OFF_STATUS: next_st.dat = {24'h00_0000, st.status};
          `RIU_OFF_BSR: next_st.dat = {28'h000_0000, st.bank_select_register};
          `RIU_OFF_CTRL: next_st.dat = {30'h0000_0000, busy, st.ext};
          `RIU_OFF_INDEX: next_st.dat = {20'h0_0000, st.index};
          `RIU_OFF_MADDR: next_st.dat = {20'h0_0000, st.maddr};
          `RIU_OFF_MDATA: next_st.dat = {24'h00_0000, mem_rdata};
          default: next_st.dat = 32'h0000_0000;
        endcase
      end
    end
    if (wr_ok) begin
      case (adr_i)
        `RIU_OFF_INSTR: begin
          if (sel_i[1]) begin
            next_st.instr = dat_i[15:0];
            next_st.state = RIU_Q1;
          end
        end
        `RIU_OFF_WREG: next_st.wreg = dat_i[7:0];
        `RIU_OFF_STATUS: next_st.status = dat_i[7:0];
        `RIU_OFF_BSR: next_st.bank_select_register = dat_i[3:0];
        `RIU_OFF_CTRL: next_st.ext = dat_i[`RIU_CTRL_EXT];
        `RIU_OFF_INDEX: begin
          if (sel_i[1]) begin
            next_st.index = dat_i[11:0];
          end
        end
        `RIU_OFF_MADDR: begin
          if (sel_i[1]) begin
            next_st.maddr = dat_i[11:0];
          end
        end
        default: next_st.dat = next_st.dat;
      endcase
    end
    case (st.state)
      RIU_IDLE: begin
        next_st.state = next_st.state;
      end
      RIU_Q1: begin
        next_st.op = dec_op;
        next_st.dest = st.instr[`RIU_IN_D];
        next_st.fadr = dec_fadr;
        next_st.state = RIU_Q2;
      end
      RIU_Q2: begin
        next_st.state = RIU_Q3;
      end
      RIU_Q3: begin
        next_st.opnd = mem_rdata;
        next_st.res = alu_res;
        next_st.cout = alu_cout;
        next_st.neg = alu_neg;
        next_st.zero = alu_zero;
        next_st.state = RIU_Q4;
      end
      RIU_Q4: begin
        // Unknown opcodes fall through as no operation
        if (st.op != RIU_OP_NONE) begin
          next_st.status[`RIU_ST_N] = st.neg;
          next_st.status[`RIU_ST_Z] = st.zero;
          if (st.op != RIU_OP_RLN) begin
            next_st.status[`RIU_ST_C] = st.cout;
          end
          if (!st.dest) begin
            next_st.wreg = st.res;
          end
        end
        next_st.state = RIU_IDLE;
      end
      default: begin
        next_st.state = RIU_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.state <= RIU_IDLE;
      st.op <= RIU_OP_NONE;
      st.wreg <= `RIU_RST_WREG;
      st.status <= `RIU_RST_STATUS;
      st.bank_select_register <= `RIU_RST_BSR;
      st.ext <= `RIU_RST_EXT;
      st.index <= `RIU_RST_INDEX;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o = st.dat;
  assign ack_o = st.ack;
  assign wreg_o = st.wreg;
  assign status_o = st.status;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_phases;
    (st.state == RIU_Q1) ##1 (st.state == RIU_Q2) ##1
    (st.state == RIU_Q3) ##1 (st.state == RIU_Q4) ##1 (st.state == RIU_IDLE);
  endsequence

  property p_phases;
    (st.state == RIU_IDLE) && wr_ok && (adr_i == `RIU_OFF_INSTR) && sel_i[1]
      |=> s_phases;
  endproperty
  a_phases: assert property (p_phases) else $error("phase walk broken");

  property p_decode;
    (st.state == RIU_Q1) && (st.instr[15:10] == `RIU_OPC_RLC) |=> (st.op == RIU_OP_RLC);
  endproperty
  a_decode: assert property (p_decode) else $error("left carry opcode missed");

  property p_rlc;
    (st.state == RIU_Q4) && (st.op == RIU_OP_RLC)
      |-> (st.res == {st.opnd[6:0], st.status[`RIU_ST_C]})
          ##1 (st.status[`RIU_ST_C] == $past(st.opnd[7]));
  endproperty
  a_rlc: assert property (p_rlc) else $error("left carry rotate wrong");

  property p_keep;
    (st.state == RIU_Q4) |=> ($past(st.status[7:5]) == st.status[7:5])
      && ($past(st.status[3]) == st.status[3]) && ($past(st.status[1]) == st.status[1]);
  endproperty
  a_keep: assert property (p_keep) else $error("untouched flag changed");

  property p_rln;
    (st.state == RIU_Q4) && (st.op == RIU_OP_RLN)
      |-> (st.res == {st.opnd[6:0], st.opnd[7]}) ##1 $stable(st.status[`RIU_ST_C]);
  endproperty
  a_rln: assert property (p_rln) else $error("circular rotate wrong");

  property p_rrc;
    (st.state == RIU_Q4) && (st.op == RIU_OP_RRC)
      |-> (st.res == {st.status[`RIU_ST_C], st.opnd[7:1]})
          ##1 (st.status[`RIU_ST_C] == $past(st.opnd[0]));
  endproperty
  a_rrc: assert property (p_rrc) else $error("right carry rotate wrong");

  property p_dest;
    (st.state == RIU_Q4) && (st.op != RIU_OP_NONE)
      |-> (mem_we == st.dest) ##1 (!$past(st.dest) -> (st.wreg == $past(st.res)));
  endproperty
  a_dest: assert property (p_dest) else $error("destination choice wrong");

  property p_bank;
    (st.state == RIU_Q1) && a_bit |=> (st.fadr == {$past(st.bank_select_register), $past(f_field)});
  endproperty
  a_bank: assert property (p_bank) else $error("bank select address wrong");

  property p_index;
    (st.state == RIU_Q1) && !a_bit && st.ext && (f_field <= `RIU_IDX_MAX)
      |=> (st.fadr == $past(st.index) + {4'h0, $past(f_field)});
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_nz;
    (st.state == RIU_Q4) && (st.op != RIU_OP_NONE)
      |=> (st.status[`RIU_ST_N] == $past(st.res[7]))
          && (st.status[`RIU_ST_Z] == ($past(st.res) == 8'h00));
  endproperty
  a_nz: assert property (p_nz) else $error("negative or zero flag wrong");
endmodule

// *** hw/riu_params.svh ***
`ifndef RIU_PARAMS_SVH
`define RIU_PARAMS_SVH

// Register byte offsets on the bus
`define RIU_OFF_INSTR 8'h00
`define RIU_OFF_WREG 8'h04
`define RIU_OFF_STATUS 8'h08
`define RIU_OFF_BSR 8'h0C
`define RIU_OFF_CTRL 8'h10
`define RIU_OFF_INDEX 8'h14
`define RIU_OFF_MADDR 8'h18
`define RIU_OFF_MDATA 8'h1C

// Opcode top six bits
`define RIU_OPC_RLC 6'h0D
`define RIU_OPC_RLN 6'h11
`define RIU_OPC_RRC 6'h0C

// Instruction field positions
`define RIU_IN_D 9
`define RIU_IN_A 8

// Status bit positions
`define RIU_ST_C 0
`define RIU_ST_Z 2
`define RIU_ST_N 4

// Control bit positions
`define RIU_CTRL_EXT 0
`define RIU_CTRL_BUSY 1

// Addressing constants
`define RIU_ACC_SPLIT 8'h60
`define RIU_IDX_MAX 8'h5F
`define RIU_ACC_LO_BANK 4'h0
`define RIU_ACC_HI_BANK 4'hF

// Reset values
`define RIU_RST_WREG 8'h00
`define RIU_RST_STATUS 8'h00
`define RIU_RST_BSR 4'h0
`define RIU_RST_EXT 1'b0
`define RIU_RST_INDEX 12'h000
`endif

// *** hw/riu_pkg.sv ***
package riu_pkg;
  // Instruction cycle phases, one-hot
  typedef enum logic [4:0] {
    RIU_IDLE = 5'h01,
    RIU_Q1 = 5'h02,
    RIU_Q2 = 5'h04,
    RIU_Q3 = 5'h08,
    RIU_Q4 = 5'h10
  } riu_state_e;
  // Decoded rotate kind
  typedef enum logic [1:0] {
    RIU_OP_NONE = 2'h0,
    RIU_OP_RLC = 2'h1,
    RIU_OP_RLN = 2'h2,
    RIU_OP_RRC = 2'h3
  } riu_op_e;
endpackage

// *** hw/riu_mem.sv ***
`timescale 1ns/10ps
// File register space, 16 banks of 256 bytes, registered read
module riu_mem (
  // Clock
  input wire logic clk_i,
  // Port
  input wire logic we_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:4095];

  // Read-first: a write shows on the read port one edge later
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// *** hw/riu_alu.sv ***
`timescale 1ns/10ps
// Rotate datapath, purely combinational
module riu_alu (
  // Operation
  input riu_pkg::riu_op_e op_i,
  input wire logic [7:0] opnd_i,
  input wire logic cin_i,
  // Result
  output logic [7:0] res_o,
  output logic cout_o,
  output logic neg_o,
  output logic zero_o
);
  import riu_pkg::*;

  // Bit movement per rotate kind
  always_comb begin
    res_o = opnd_i;
    cout_o = cin_i;
    case (op_i)
      RIU_OP_RLC: begin
        res_o = {opnd_i[6:0], cin_i};
        cout_o = opnd_i[7];
      end
      RIU_OP_RLN: begin
        res_o = {opnd_i[6:0], opnd_i[7]};
      end
      RIU_OP_RRC: begin
        res_o = {cin_i, opnd_i[7:1]};
        cout_o = opnd_i[0];
      end
      default: begin
        res_o = opnd_i;
      end
    endcase
  end

  assign neg_o = res_o[7];
  assign zero_o = (res_o == 8'h00);
endmodule

// *** tb/riu_top_tb.sv ***
`timescale 1ns/10ps
`include "riu_params.svh"
// ==========================================
// Bench for the rotate instruction unit
module riu_top_tb;
  import riu_pkg::*;

  // Compare one value, count it, report a mismatch at once
  `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [7:0] wreg_o;
  logic [7:0] status_o;
  int error_cnt = 0;
  int checked = 0;

  // ==========================================
  // Clock and device
  always #5 clk_i = ~clk_i;

  riu_top u_riu_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .wreg_o(wreg_o), .status_o(status_o));

  // ==========================================
  // Bus tasks
  // One classic cycle; the leading edge wait leaves the idle gap
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // Hold the request until ack is sampled; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(nm, e, q)
  endtask

  // One instruction on a prepared operand; expected values from the bit rules
  task do_op(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
    input logic [11:0] ad, input logic [7:0] o, input logic [7:0] st);
    logic [7:0] r;
    logic c;
    logic hit;
    logic [7:0] es;
    hit = 1'b1;
    c = st[0];
    r = o;
    case (op)
      `RIU_OPC_RLC: {c, r} = {o, st[0]};
      `RIU_OPC_RLN: r = {o[6:0], o[7]};
      `RIU_OPC_RRC: {r, c} = {st[0], o};
      default: hit = 1'b0;
    endcase
    es = hit ? {st[7:5], r[7], st[3], r == 8'h00, st[1], c} : st;
    wr(`RIU_OFF_STATUS, {24'h0, st});
    wr(`RIU_OFF_WREG, 32'h5A);
    wr(`RIU_OFF_MADDR, {20'h0, ad});
    wr(`RIU_OFF_MDATA, {24'h0, o});
    wr(`RIU_OFF_INSTR, {16'h0, op, d, a, f});
    // Results land on the fourth edge after the taking edge; the write returned on the first
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("wreg", (hit && !d) ? r : 8'h5A, wreg_o)
    `CHK("status", es, status_o)
    rchk("mem", `RIU_OFF_MDATA, {24'h0, (hit && d) ? r : o});
  endtask

  // ==========================================
  // Verdict, reached from the sequence or the watchdog
  task results;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    results;
  end

  // ==========================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, skipping the unreset memory window
    for (int i = 0; i < 7; i++) begin
      rchk("reset", 8'(i * 4), 32'h0);
    end
    wr(8'h24, 32'hFF);
    rchk("unmapped", 8'h24, 32'h0);
    // Write without the low byte lane must be dropped
    sel <= 4'hE;
    wr(`RIU_OFF_WREG, 32'h77);
    sel <= 4'hF;
    rchk("wreg lane", `RIU_OFF_WREG, 32'h0);
    $display("test registers done");

    wr(`RIU_OFF_BSR, 32'h3);
    wr(`RIU_OFF_INDEX, 32'h200);
    do_op(`RIU_OPC_RLC, 0, 0, 8'h10, 12'h010, 8'hE6, 8'hE2);
    do_op(`RIU_OPC_RLC, 1, 0, 8'h70, 12'hF70, 8'h80, 8'h1C);
    do_op(`RIU_OPC_RLN, 1, 1, 8'h45, 12'h345, 8'hAB, 8'hE3);
    do_op(`RIU_OPC_RLN, 0, 1, 8'hFF, 12'h3FF, 8'h7F, 8'h00);
    do_op(`RIU_OPC_RRC, 1, 0, 8'h5F, 12'h05F, 8'hE6, 8'h01);
    // Extended set on: low access half goes through the index base
    wr(`RIU_OFF_CTRL, 32'h1);
    do_op(`RIU_OPC_RRC, 0, 0, 8'h5F, 12'h25F, 8'hE6, 8'hE0);
    do_op(`RIU_OPC_RLC, 1, 0, 8'h60, 12'hF60, 8'h01, 8'h01);
    do_op(`RIU_OPC_RLC, 1, 1, 8'h10, 12'h310, 8'h55, 8'h00);
    do_op(6'h0E, 1, 0, 8'h60, 12'hF60, 8'h81, 8'h15);
    $display("test rotate done");

    // A write landing while the instruction runs is dropped
    wr(`RIU_OFF_WREG, 32'h11);
    // Operand byte at bank 3 offset 45 was written by an earlier rotate
    wr(`RIU_OFF_INSTR, {16'h0, `RIU_OPC_RLN, 2'b11, 8'h45});
    wr(`RIU_OFF_WREG, 32'h33);
    repeat (6) @(posedge clk_i);
    rchk("busy write", `RIU_OFF_WREG, 32'h11);
    rchk("ctrl", `RIU_OFF_CTRL, 32'h1);
    // Busy must read back set while the phases run
    wr(`RIU_OFF_INSTR, {16'h0, `RIU_OPC_RLN, 2'b11, 8'h45});
    rchk("ctrl busy", `RIU_OFF_CTRL, 32'h3);
    repeat (4) @(posedge clk_i);
    $display("test busy done");
    results;
  end
endmodule
